// [tb/cpu_model.sv]
// CPU stand-in: issues the halt instruction as a one-cycle pulse.
// Assumes go is a one-cycle request on mclk.
module cpu_model
(
  input wire mclk,
  input wire rstn,
  input wire go,
  input wire cpu_halt_r,
  output logic halt_exec
);
  timeunit 1ns;
  timeprecision 1ns;
  // A halted CPU executes nothing, so no pulse while halted.
  always @(posedge mclk or negedge rstn)
    if (!rstn)
      halt_exec <= 1'b0;
    else
      halt_exec <= go && !halt_exec && !cpu_halt_r;
endmodule

// [tb/power_down_mode_control_test.sv]
// Testbench for the power-down controller.
// Assumes the checker is bound in and the CPU model drives halts.
module power_down_mode_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rstn = 0, read = 0, write = 0, go = 0, irq_any = 0;
  logic ext_wake_irq = 0, hwsb_n = 1, init_n = 1;
  logic [3:0] address = 4'h0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest, halt_exec, cpu_halt_r, clock_stop_r, chip_reset_r;
  logic ram_en, rpi;
  logic [5:0] mstop, mrst;
  logic [7:0] q;
  int fails = 0, total_checks = 0, cyc = 0, n;
  always #25 mclk = ~mclk;
  cpu_model i_cpu (.mclk(mclk), .rstn(rstn), .go(go),
    .cpu_halt_r(cpu_halt_r), .halt_exec(halt_exec));
  pwr_down_ctrl #(.WAIT0(8), .WAIT1(16), .WAIT2(32)) i_dut (.mclk(mclk),
    .rstn(rstn), .ce(1'b1), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'h1), .readdata(readdata),
    .waitrequest(waitrequest), .halt_exec(halt_exec), .irq_any(irq_any),
    .ext_wake_irq(ext_wake_irq), .hw_standby_pin_n(hwsb_n),
    .chip_init_pin_n(init_n), .cpu_halt_r(cpu_halt_r),
    .clock_stop_r(clock_stop_r), .chip_reset_r(chip_reset_r),
    .onchip_ram_enable_r(ram_en), .module_stop_r(mstop),
    .module_reset_r(mrst), .refresh_part_init_r(rpi));
  task summarize;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task tick(input int k);
    repeat (k) @(posedge mclk);
  endtask
  // Request held until waitrequest is sampled low at a rising edge.
  task bus(input logic rd, input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    read <= rd;
    write <= !rd;
    address <= a;
    writedata <= {24'h0, d};
    do @(posedge mclk); while (waitrequest !== 1'b0);
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task halt;
    go <= 1'b1;
    tick(1);
    go <= 1'b0;
    tick(2);
  endtask
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      summarize;
    end
  end
  initial
  begin
    tick(2);
    rstn <= 1'b1;
    bus(1, 4'h0, 0);
    chk(q, 8'h0b);
    bus(1, 4'h4, 0);
    chk(q, 8'h40);
    bus(1, 4'hc, 0);
    chk(q, 8'h00);
    bus(0, 4'h4, 8'hff);
    tick(2);
    chk(rpi, 1'b1);
    tick(1);
    chk(mstop, 6'h3f);
    chk(mrst, 6'h2f);
    bus(0, 4'h4, 8'h00);
    tick(3);
    chk(mstop, 6'h00);
    $display("module standby test done");
    halt;
    chk({cpu_halt_r, clock_stop_r}, 2'b10);
    bus(1, 4'h8, 0);
    chk(q, 8'h01);
    bus(0, 4'h4, 8'h01);
    tick(3);
    chk(mstop, 6'h01);
    irq_any <= 1'b1;
    tick(2);
    chk(cpu_halt_r, 1'b0);
    irq_any <= 1'b0;
    bus(0, 4'h4, 8'h00);
    halt;
    init_n <= 1'b0;
    tick(5);
    chk(chip_reset_r, 1'b1);
    init_n <= 1'b1;
    tick(6);
    chk(chip_reset_r, 1'b0);
    chk(cpu_halt_r, 1'b0);
    $display("sleep test done");
    for (int w = 0; w < 3; w++)
    begin
      bus(0, 4'h0, {1'b1, w[2:0], 4'hb});
      halt;
      chk(clock_stop_r, 1'b1);
      ext_wake_irq <= 1'b1;
      tick(1);
      ext_wake_irq <= 1'b0;
      n = 0;
      while (cpu_halt_r && n < 100)
      begin
        tick(1);
        n++;
      end
      chk(n, (8 << w) + 2);
      bus(1, 4'h0, 0);
      chk(q, {1'b1, w[2:0], 4'hb});
    end
    $display("software standby test done");
    bus(0, 4'h0, 8'h0a);
    tick(2);
    chk(ram_en, 1'b0);
    hwsb_n <= 1'b0;
    tick(5);
    chk(chip_reset_r, 1'b1);
    chk({clock_stop_r, mrst}, 7'h7f);
    hwsb_n <= 1'b1;
    tick(6);
    chk(chip_reset_r, 1'b0);
    bus(1, 4'h0, 0);
    chk({ram_en, q}, 9'h10b);
    $display("hardware standby test done");
    summarize;
  end
endmodule

// [tb/pwr_down_sva.sv]
// Assertions on the power-down controller ports.
// Assumes mclk is the only clock and ce is held high in checks.
module pwr_down_sva
#(
  parameter WAIT0 = 8192,
  parameter WAIT1 = 16384,
  parameter WAIT2 = 32768
)
(
  // Clock, reset and enable.
  input wire mclk,
  input wire rstn,
  input wire ce,
  // Register bus.
  input wire [3:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  input wire [31:0] readdata,
  input wire waitrequest,
  // CPU side and standby pin.
  input wire halt_exec,
  input wire irq_any,
  input wire hw_standby_pin_n,
  // Power outputs.
  input wire cpu_halt_r,
  input wire clock_stop_r,
  input wire chip_reset_r,
  input wire [5:0] module_stop_r,
  input wire [5:0] module_reset_r,
  input wire refresh_part_init_r
);
  timeunit 1ns;
  timeprecision 1ns;
  logic swsb_r;
  logic sw_r;
  logic [2:0] ws_r;
  int cnt_r;
  wire acc = write && !waitrequest && byteenable[0];
  wire sys_wr = acc && address == 4'h0;
  wire mh_wr = acc && address == 4'h4;
  wire [31:0] wn = ws_r == 3'h0 ? WAIT0 : ws_r == 3'h1 ? WAIT1 : WAIT2;
  // Shadow of the select bits; a deep standby wipes them as the block does.
  always @(posedge mclk or negedge rstn)
    if (!rstn || chip_reset_r)
    begin
      swsb_r <= 1'b0;
      ws_r <= 3'h0;
    end
    else if (sys_wr)
    begin
      swsb_r <= writedata[7];
      ws_r <= writedata[6:4];
    end
  // Counts settle cycles; cleared on each entry into a stopped clock.
  always @(posedge mclk or negedge rstn)
    if (!rstn)
    begin
      sw_r <= 1'b0;
      cnt_r <= 0;
    end
    else if (clock_stop_r)
    begin
      sw_r <= !chip_reset_r;
      cnt_r <= 0;
    end
    else
    begin
      if (!cpu_halt_r)
        sw_r <= 1'b0;
      if (cpu_halt_r)
        cnt_r <= cnt_r + 1;
    end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn || !ce);
  sleep_enter_a: assert property (
    halt_exec && !cpu_halt_r && !swsb_r && !chip_reset_r
    |=> cpu_halt_r && !clock_stop_r) else $error("no sleep");
  swsb_enter_a: assert property (
    halt_exec && !cpu_halt_r && swsb_r && !chip_reset_r
    |=> cpu_halt_r && clock_stop_r) else $error("no standby");
  hw_standby_a: assert property (
    !hw_standby_pin_n [*3] |-> ##[1:2]
    (chip_reset_r && clock_stop_r && cpu_halt_r))
    else $error("no hw standby");
  sleep_exit_a: assert property (
    cpu_halt_r && !clock_stop_r && irq_any && !chip_reset_r && !swsb_r
    |=> !cpu_halt_r) else $error("no wake");
  mod_stop_a: assert property (
    mh_wr && !cpu_halt_r |-> ##2
    module_stop_r == $past(writedata[5:0], 2)) else $error("bad stop");
  mod_reset_a: assert property (
    {module_reset_r[5], module_reset_r[3:0]} ==
    {module_stop_r[5], module_stop_r[3:0]}) else $error("bad reset");
  refresh_keep_a: assert property (
    !chip_reset_r |-> !module_reset_r[4]) else $error("refresh wiped");
  refresh_init_a: assert property (
    $rose(module_stop_r[4]) && !clock_stop_r
    |-> ##[0:1] refresh_part_init_r) else $error("no part init");
  select_keep_a: assert property (
    read && !waitrequest && address == 4'h0
    |-> readdata[7:4] == {swsb_r, ws_r}) else $error("bad select");
  settle_len_a: assert property (
    sw_r && $fell(cpu_halt_r) |-> cnt_r == wn + 1) else $error("bad settle");
  cover property (halt_exec && !swsb_r ##1 cpu_halt_r);
  cover property (sw_r && $fell(cpu_halt_r));
  cover property ($rose(chip_reset_r));
endmodule

bind pwr_down_ctrl pwr_down_sva #(.WAIT0(WAIT0), .WAIT1(WAIT1),
  .WAIT2(WAIT2)) i_sva (.mclk(mclk), .rstn(rstn), .ce(ce),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
  .halt_exec(halt_exec), .irq_any(irq_any),
  .hw_standby_pin_n(hw_standby_pin_n), .cpu_halt_r(cpu_halt_r),
  .clock_stop_r(clock_stop_r), .chip_reset_r(chip_reset_r),
  .module_stop_r(module_stop_r), .module_reset_r(module_reset_r),
  .refresh_part_init_r(refresh_part_init_r));

// [verilog/pwr_consts.vh]
// Constants for the power-down mode controller: register offsets,
// field positions, reset values and settling wait counts.
// Included by the controller and its settling timer.
`ifndef PWR_CONSTS_VH
`define PWR_CONSTS_VH

// Byte offsets on the register bus, one 32-bit word each.
`define OFF_SYSCTL 4'h0
`define OFF_MODHALT 4'h4
`define OFF_STATUS 4'h8

// Reset values.
`define SYSCTL_RST 8'h0b
`define MODHALT_RST 8'h40

// System control register fields.
`define STANDBY_SEL_BIT 7
`define WSEL_HI 6
`define WSEL_LO 4
`define RAM_EN_BIT 0

// Module halt register bit positions.
`define MH_TIMER 0
`define MH_SER0 1
`define MH_SER1 2
`define MH_DMA 3
`define MH_REFRESH 4
`define MH_ADC 5
`define MH_NUM 6

// Settling waits in states, one state per system clock.
`define WAIT_SEL0 8192
`define WAIT_SEL1 16384
`define WAIT_SEL2 32768

`endif

// [verilog/pwr_down_ctrl.v]
// Power-down mode controller: sleep, software and hardware standby,
// and the per-module standby function, with an Avalon-MM register slave.
// Assumes the CPU and interrupt logic share mclk; the two pins are async.
//
// What this block does
// - Halt with standby select clear enters sleep; clock keeps running.
// - Halt instruction with standby select set enters software standby.
// - Hardware standby pin low enters hardware standby from anywhere.
// - Sleep ends on any interrupt, init pin or hardware standby pin.
// - Module standby halts chosen modules in any power-down mode.
// - Only timer, serial channels, DMA, refresh and converter can halt.
// - A module halt bit at one puts that module into standby.
// - A module halt bit at one holds that module's registers in reset, refresh excepted.
// - Halted refresh block clears only its counter and two status bits.
// - Standby select stays set after wake-up until software or a hardware standby or init clears it.
// - Wake from software standby waits 8192, 16384 or 32768 states.
`include "pwr_consts.vh"

module pwr_down_ctrl
#(
  parameter WAIT0 = `WAIT_SEL0,
  parameter WAIT1 = `WAIT_SEL1,
  parameter WAIT2 = `WAIT_SEL2
)
(
  // Clock, reset and enable.
  input wire mclk,
  input wire rstn,
  input wire ce,
  // Avalon-MM slave.
  input wire [3:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata,
  output reg waitrequest,
  // CPU and interrupt side.
  input wire halt_exec,
  input wire irq_any,
  input wire ext_wake_irq,
  // Pins.
  input wire hw_standby_pin_n,
  input wire chip_init_pin_n,
  // Power control outputs.
  output reg cpu_halt_r,
  output reg clock_stop_r,
  output reg chip_reset_r,
  output reg onchip_ram_enable_r,
  output reg [5:0] module_stop_r,
  output reg [5:0] module_reset_r,
  output reg refresh_part_init_r
);

  localparam ST_RUN = 3'h0;
  localparam ST_SLEEP = 3'h1;
  localparam ST_SWSTBY = 3'h2;
  localparam ST_SETTLE = 3'h3;
  localparam ST_HWSTBY = 3'h4;
  localparam ST_INIT = 3'h5;
  localparam [7:0] SYSCTL_INIT = `SYSCTL_RST;

  reg [1:0] hwsb_sync_r;
  reg [1:0] init_sync_r;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [7:0] system_control_reg;
  reg [7:0] module_halt_reg;
  reg [5:0] halt_prev_r;
  reg settle_load;
  wire settle_done;
  wire hwsb_low;
  wire init_low;
  wire bus_req;
  wire wr_take;
  wire stopped;
  wire deep;

  // Wait length for the selected field; codes above two use the longest.
  function [15:0] wait_count;
    input [2:0] sel;
    reg [31:0] full;
    begin
      case (sel)
        3'h0: full = WAIT0 - 1;
        3'h1: full = WAIT1 - 1;
        default: full = WAIT2 - 1;
      endcase
      // The longest wait still fits in the timer's sixteen bits.
      wait_count = full[15:0];
    end
  endfunction

  // Pins pass two flip-flops before anything reads them.
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      hwsb_sync_r <= 2'h3;
      init_sync_r <= 2'h3;
    end
    else if (ce)
    begin
      hwsb_sync_r <= {hwsb_sync_r[0], hw_standby_pin_n};
      init_sync_r <= {init_sync_r[0], chip_init_pin_n};
    end
  end

  assign hwsb_low = ~hwsb_sync_r[1];
  assign init_low = ~init_sync_r[1];

  // Mode sequencing; standby pin outranks the init pin, which outranks
  // everything the CPU does.
  always @*
  begin
    state_nxt = state_r;
    settle_load = 1'b0;
    if (hwsb_low)
      state_nxt = ST_HWSTBY;
    else if (init_low)
      state_nxt = ST_INIT;
    else
    begin
      case (state_r)
        ST_RUN:
        begin
          if (halt_exec)
          begin
            if (system_control_reg[`STANDBY_SEL_BIT])
              state_nxt = ST_SWSTBY;
            else
              state_nxt = ST_SLEEP;
          end
        end
        ST_SLEEP:
        begin
          if (irq_any)
            state_nxt = ST_RUN;
        end
        ST_SWSTBY:
        begin
          if (ext_wake_irq)
          begin
            state_nxt = ST_SETTLE;
            settle_load = 1'b1;
          end
        end
        ST_SETTLE:
        begin
          if (settle_done)
            state_nxt = ST_RUN;
        end
        ST_HWSTBY:
          state_nxt = ST_INIT;
        ST_INIT:
          state_nxt = ST_RUN;
        default:
          state_nxt = ST_INIT;
      endcase
    end
  end

  settle_timer u_settle
  (
    .mclk(mclk),
    .rstn(rstn),
    .ce(ce),
    .load(settle_load),
    .load_val(wait_count(system_control_reg[`WSEL_HI:`WSEL_LO])),
    .expired(settle_done)
  );

  assign stopped = (state_nxt == ST_SWSTBY) || (state_nxt == ST_SETTLE) ||
    (state_nxt == ST_HWSTBY) || (state_nxt == ST_INIT);
  assign deep = (state_nxt == ST_HWSTBY) || (state_nxt == ST_INIT);

  // Bus: a request is acknowledged one cycle after it is seen, and a
  // write lands on the edge where the master samples waitrequest low.
  assign bus_req = (read | write) & waitrequest;
  assign wr_take = write & ~waitrequest;

  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= ST_RUN;
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
      system_control_reg <= `SYSCTL_RST;
      module_halt_reg <= `MODHALT_RST;
      halt_prev_r <= 6'h00;
    end
    else if (ce)
    begin
      state_r <= state_nxt;
      waitrequest <= ~bus_req;
      if (bus_req && read)
      begin
        case (address)
          `OFF_SYSCTL: readdata <= {24'h000000, system_control_reg};
          `OFF_MODHALT: readdata <= {24'h000000, module_halt_reg};
          `OFF_STATUS: readdata <= {29'h00000000, state_r};
          default: readdata <= 32'h00000000;
        endcase
      end
      // Chip initialisation restores both registers, whatever the bus does.
      if (deep)
      begin
        system_control_reg <= `SYSCTL_RST;
        module_halt_reg <= `MODHALT_RST;
      end
      else if (wr_take && byteenable[0])
      begin
        // Standby select is changed only here or by a deep standby restore, never by a wake-up.
        if (address == `OFF_SYSCTL)
          system_control_reg <= writedata[7:0];
        if (address == `OFF_MODHALT)
          module_halt_reg <= writedata[7:0];
      end
      halt_prev_r <= module_halt_reg[5:0];
    end
  end

  // Power outputs, all registered.
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      cpu_halt_r <= 1'b0;
      clock_stop_r <= 1'b0;
      chip_reset_r <= 1'b1;
      onchip_ram_enable_r <= SYSCTL_INIT[`RAM_EN_BIT];
      module_stop_r <= 6'h00;
      module_reset_r <= 6'h00;
      refresh_part_init_r <= 1'b0;
    end
    else if (ce)
    begin
      cpu_halt_r <= (state_nxt != ST_RUN);
      clock_stop_r <= (state_nxt == ST_SWSTBY) || deep;
      chip_reset_r <= deep;
      // Software must drop this bit before the standby pin falls.
      onchip_ram_enable_r <= system_control_reg[`RAM_EN_BIT];
      // Halt bits act in every mode, only the low six bits do anything.
      module_stop_r <= module_halt_reg[5:0] |
        {6{stopped}};
      // A halted module other than refresh is held in reset, so a restart needs a clear of
      // the bit before any reprogramming can stick.
      module_reset_r <= (module_halt_reg[5:0] | {6{stopped}}) &
        ~(6'h01 << `MH_REFRESH);
      // The refresh block keeps its setup in module and software standby.
      module_reset_r[`MH_REFRESH] <= deep;
      refresh_part_init_r <= (module_halt_reg[`MH_REFRESH] &
        ~halt_prev_r[`MH_REFRESH]) |
        ((state_nxt == ST_SWSTBY) & (state_r != ST_SWSTBY));
    end
  end

endmodule

// [verilog/settle_timer.v]
// Down counter that times the clock-settling wait after software standby.
// Assumes load is a one-cycle pulse on the same clock as the controller.
`include "pwr_consts.vh"

module settle_timer
(
  // Clock, reset and enable.
  input wire mclk,
  input wire rstn,
  input wire ce,
  // Control.
  input wire load,
  input wire [15:0] load_val,
  // Status.
  output reg expired
);

  reg [15:0] count_r;
  reg run_r;

  // Expired is a one-cycle pulse when the loaded count has elapsed.
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      count_r <= 16'h0000;
      run_r <= 1'b0;
      expired <= 1'b0;
    end
    else if (ce)
    begin
      expired <= 1'b0;
      if (load)
      begin
        count_r <= load_val;
        run_r <= 1'b1;
      end
      else if (run_r)
      begin
        if (count_r == 16'h0000)
        begin
          run_r <= 1'b0;
          expired <= 1'b1;
        end
        else
          count_r <= count_r - 16'h0001;
      end
    end
  end

endmodule
